//--- design/bcm_boot_clk_sel.sv
// Purpose: reset-time boot selection, core clock divide and flash control
// Assumes: straps are asynchronous pins; register port is on clk
// Notes:   erase times are parameters so simulations can shorten them
`timescale 1ns/100ps
`default_nettype none
module bcm_boot_clk_sel
   import bcm_pkg::*;
#(
   parameter longint BLK_ERASE_CYCLES  = BLK_ERASE_CYC,
   parameter longint CHIP_ERASE_CYCLES = CHIP_ERASE_CYC
) (
   input  wire logic        clk,          // 20 MHz core clock
   input  wire logic        srst,         // synchronous reset, high
   input  wire logic        prog_strobe_pin,  // program store strobe pin, low active
   input  wire logic        ext_access_pin,   // external access pin, low active
   input  wire logic        addr_latch_pin,   // address latch strobe pin
   input  wire logic [7:0]  reg_addr,     // register index
   input  wire logic [7:0]  reg_wdata,    // register write data
   input  wire logic        reg_wr,       // write strobe
   input  wire logic        reg_rd,       // read strobe
   output logic      [7:0]  reg_rdata,    // read data, cycle after strobe
   output logic             core_tick,    // one core cycle pulse
   output logic             six_clk_mode, // one when six-clock mode
   output logic             boot_valid,   // boot decision taken
   output logic             boot_loader,  // one when loader selected
   output logic      [15:0] start_addr,   // start address chosen
   output logic             ext_code      // code fetched externally
);
   localparam int unsigned CW = 32;

   // synchronisers for the three strap pins
   bcm_strap_s strap_s1_ff, strap_s2_ff;
   always_ff @(posedge clk) begin
      strap_s1_ff <= '{prog_strobe_pin, ext_access_pin, addr_latch_pin};
      strap_s2_ff <= strap_s1_ff;
   end

   // register state
   logic [7:0] ckc_ff;
   // nonvolatile bits start at their shipped value and are not touched by srst
   logic       fuse_ff  = 1'b0;          // one = programmed
   logic [7:0] bstat_ff = BOOT_STAT_RST;
   logic [2:0] sec_ff   = 3'h0;          // security bits, erased as shipped
   logic [15:0] faddr_ff;
   logic [7:0] fdata_ff;
   logic [7:0] rdata_ff;
   bcm_state_e st_ff;
   bcm_cmd_e   cmd_ff;
   logic [CW-1:0] cnt_ff;
   logic [15:0] ers_ptr_ff;
   logic        busy;
   logic        cmd_wr;
   logic [7:0]  mem_rdata;

   assign busy   = (st_ff != BCM_ST_IDLE);
   assign cmd_wr = reg_wr && (reg_addr == REG_FLASH_CMD) && !busy;

   // effective clock mode: fuse overrides, else select bit
   assign six_clk_mode = fuse_ff | ckc_ff[CKC_SEL_BIT];

   // core tick divider; count is not cleared on a mode change, the >= compare cuts an overlong count short
   logic [3:0] div_ff;
   always_ff @(posedge clk) begin
      if (srst) begin
         div_ff <= 4'h0;
      end else if (core_tick) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end
   assign core_tick = (div_ff >= (six_clk_mode ? DIV6_LAST : DIV12_LAST));

   // clock control: only select bit writable, bit 7 fixed one
   always_ff @(posedge clk) begin
      if (srst) begin
         ckc_ff <= CKC_RST;
      end else if (reg_wr && reg_addr == REG_CLK_CTRL) begin
         ckc_ff <= (reg_wdata & CKC_WMASK) | CKC_RST;
      end
   end

   // boot decision once per reset release; held until next reset
   logic boot_done_ff;
   logic boot_ldr_ff;
   logic ext_code_ff;
   logic strap_force;
   assign strap_force = !strap_s2_ff.prog_strobe_n && strap_s2_ff.ext_access_n
                        && strap_s2_ff.addr_latch;
   always_ff @(posedge clk) begin
      if (srst) begin
         boot_done_ff <= 1'b0;
         boot_ldr_ff  <= 1'b0;
      end else if (!boot_done_ff) begin
         boot_done_ff <= 1'b1;
         boot_ldr_ff  <= (bstat_ff != 8'h00) || strap_force;
      end
   end
   // external access: latched at release when security bit one set
   always_ff @(posedge clk) begin
      if (srst) begin
         ext_code_ff <= 1'b0;
      end else if (!boot_done_ff || !sec_ff[0]) begin
         ext_code_ff <= !strap_s2_ff.ext_access_n;
      end
   end
   assign boot_valid  = boot_done_ff;
   assign boot_loader = boot_ldr_ff;
   assign ext_code    = ext_code_ff;
   assign start_addr  = boot_ldr_ff ? LOADER_START : USER_START;

   // register port latches for flash address and data
   always_ff @(posedge clk) begin
      if (srst) begin
         faddr_ff <= 16'h0000;
         fdata_ff <= 8'h00;
      end else if (reg_wr && reg_addr == REG_FLASH_ADDR_L) begin
         faddr_ff[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_FLASH_ADDR_H) begin
         faddr_ff[15:8] <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_FLASH_DATA) begin
         fdata_ff <= reg_wdata;
      end
   end

   // flash engine: timed program, block erase, chip erase
   logic [CW-1:0] op_len;
   always_comb begin
      op_len = CW'(PROG_CYC);
      if (reg_wdata[2:0] == BCM_CMD_BLKER) begin
         op_len = CW'(BLK_ERASE_CYCLES);
      end else if (reg_wdata[2:0] == BCM_CMD_CHIP) begin
         op_len = CW'(CHIP_ERASE_CYCLES);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff  <= BCM_ST_IDLE;
         cmd_ff <= BCM_CMD_NONE;
         cnt_ff <= '0;
      end else begin
         case (st_ff)
            BCM_ST_IDLE: begin
               if (cmd_wr && reg_wdata[2:0] != BCM_CMD_NONE) begin
                  cmd_ff <= bcm_cmd_e'(reg_wdata[2:0]);
                  cnt_ff <= op_len;
                  st_ff  <= BCM_ST_WORK;
               end
            end
            BCM_ST_WORK: begin
               if (cnt_ff <= CW'(1)) begin
                  st_ff <= BCM_ST_ERASE;
               end else begin
                  cnt_ff <= cnt_ff - CW'(1);
               end
            end
            BCM_ST_ERASE: begin
               // array sweep for erase commands, one byte per clock
               if (cmd_ff == BCM_CMD_CHIP) begin
                  if (ers_ptr_ff == 16'hffff) st_ff <= BCM_ST_DONE;
               end else if (cmd_ff == BCM_CMD_BLKER) begin
                  if (ers_ptr_ff[11:0] == 12'hfff) st_ff <= BCM_ST_DONE;
               end else begin
                  st_ff <= BCM_ST_DONE;
               end
            end
            default: st_ff <= BCM_ST_IDLE;
         endcase
      end
   end

   // erase sweep pointer starts at block base or zero
   always_ff @(posedge clk) begin
      if (srst) begin
         ers_ptr_ff <= 16'h0000;
      end else if (st_ff == BCM_ST_WORK) begin
         ers_ptr_ff <= (cmd_ff == BCM_CMD_CHIP) ? 16'h0000 : {faddr_ff[15:12], 12'h000};
      end else if (st_ff == BCM_ST_ERASE) begin
         ers_ptr_ff <= ers_ptr_ff + 16'h0001;
      end
   end

   // nonvolatile bits: status byte, fuse, security bits; srst leaves them
   // alone, otherwise a cleared status byte could never reach the boot pick
   logic op_end;
   assign op_end = (st_ff == BCM_ST_DONE);
   always_ff @(posedge clk) begin
      if (op_end && !srst) begin
         case (cmd_ff)
            BCM_CMD_CHIP: begin
               bstat_ff <= ERASED_BYTE;
               fuse_ff  <= 1'b0;
               sec_ff   <= 3'h0;
            end
            BCM_CMD_BSTAT: bstat_ff <= 8'h00;
            BCM_CMD_FUSE:  fuse_ff  <= 1'b1;
            BCM_CMD_SEC:   sec_ff   <= sec_ff | (3'h1 << fdata_ff[1:0]);
            default: ;
         endcase
      end
   end

   // array write: program byte at end or erase sweep
   logic        mem_we;
   logic [15:0] mem_waddr;
   logic [7:0]  mem_wdata;
   assign mem_we = (st_ff == BCM_ST_ERASE && (cmd_ff == BCM_CMD_CHIP || cmd_ff == BCM_CMD_BLKER))
                   || (op_end && cmd_ff == BCM_CMD_PROG && !sec_ff[0]);
   assign mem_waddr = (st_ff == BCM_ST_ERASE) ? ers_ptr_ff : faddr_ff;
   assign mem_wdata = (st_ff == BCM_ST_ERASE) ? ERASED_BYTE : (fdata_ff & mem_rdata); // bits only clear

   bcm_flash_mem #(.AW(16)) u_mem (
      .clk      (clk),
      .we       (mem_we),
      .waddr    (mem_waddr),
      .wdata    (mem_wdata),
      .raddr    (faddr_ff),
      .rdata_ff (mem_rdata)
   );

   // register read mux, answered in the next cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == REG_CLK_CTRL) begin
            rdata_ff <= ckc_ff;
         end else if (reg_addr == REG_BOOT_STAT) begin
            rdata_ff <= bstat_ff;
         end else if (reg_addr == REG_FLASH_ADDR_L) begin
            rdata_ff <= faddr_ff[7:0];
         end else if (reg_addr == REG_FLASH_ADDR_H) begin
            rdata_ff <= faddr_ff[15:8];
         end else if (reg_addr == REG_FLASH_DATA) begin
            rdata_ff <= (sec_ff[1]) ? 8'h00 : mem_rdata; // verify inhibited
         end else if (reg_addr == REG_FLASH_STAT) begin
            rdata_ff <= {4'h0, sec_ff, busy};
         end else if (reg_addr == REG_BOOT_INFO) begin
            rdata_ff <= {3'h0, ext_code_ff, fuse_ff, six_clk_mode, boot_ldr_ff, boot_done_ff};
         end else begin
            rdata_ff <= 8'h00;
         end
      end else begin
         rdata_ff <= 8'h00;
      end
   end
   assign reg_rdata = rdata_ff;

   // checks
   a_fuse_forces_six:   assert property (@(posedge clk) disable iff (srst)
      fuse_ff |-> six_clk_mode) else $error("fuse set but not six-clock");
   a_sel_picks_mode:    assert property (@(posedge clk) disable iff (srst)
      !fuse_ff |-> (six_clk_mode == ckc_ff[0])) else $error("select bit ignored");
   a_tick_twelve:       assert property (@(posedge clk) disable iff (srst)
      (core_tick && !six_clk_mode && $stable(six_clk_mode)) ##1 (!six_clk_mode)[*8] |-> !core_tick)
      else $error("twelve divide too short");
   a_chip_erase_fuse:   assert property (@(posedge clk) disable iff (srst)
      (op_end && cmd_ff == BCM_CMD_CHIP) |=> (!fuse_ff && bstat_ff == 8'hff)) else $error("chip erase left state");
   a_stat_only_chip:    assert property (@(posedge clk) disable iff (srst)
      ($past(bstat_ff) == 8'h00 && bstat_ff != 8'h00) |-> $past(op_end && cmd_ff == BCM_CMD_CHIP))
      else $error("status byte raised without chip erase");
   a_boot_pick:         assert property (@(posedge clk) disable iff (srst)
      $rose(boot_done_ff) |-> (boot_ldr_ff == ($past(bstat_ff) != 8'h00 || $past(strap_force))))
      else $error("wrong boot pick");
   a_boot_held:         assert property (@(posedge clk) disable iff (srst)
      $past(boot_done_ff) |-> $stable(boot_ldr_ff)) else $error("boot choice changed");
   a_start_addr:        assert property (@(posedge clk) disable iff (srst)
      boot_ldr_ff |-> start_addr == LOADER_START) else $error("loader start wrong");
   a_fixed_bit_one:     assert property (@(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == REG_CLK_CTRL) |=> reg_rdata[7] && reg_rdata[6:1] == 6'h00)
      else $error("fixed bits read wrong");
   c_loader_boot:  cover property (@(posedge clk) $rose(boot_done_ff) ##1 boot_ldr_ff);
   c_user_boot:    cover property (@(posedge clk) $rose(boot_done_ff) ##1 !boot_ldr_ff);
   c_six_mode:     cover property (@(posedge clk) core_tick && six_clk_mode);
   c_chip_erase:   cover property (@(posedge clk) op_end && cmd_ff == BCM_CMD_CHIP);
endmodule
`default_nettype wire

//--- design/bcm_pkg.sv
// Purpose: shared constants and types for the boot and clock mode select block
// Assumes: 20 MHz clk, byte wide register port with 8-bit word index
// Notes:   flash timings are kept in their own units and converted to cycles here
package bcm_pkg;
   localparam int unsigned CLK_HZ          = 20000000;
   // register indices on the plain register port
   localparam logic [7:0]  REG_CLK_CTRL    = 8'h00;
   localparam logic [7:0]  REG_BOOT_STAT   = 8'h01;
   localparam logic [7:0]  REG_FLASH_ADDR_L = 8'h02;
   localparam logic [7:0]  REG_FLASH_ADDR_H = 8'h03;
   localparam logic [7:0]  REG_FLASH_DATA  = 8'h04;
   localparam logic [7:0]  REG_FLASH_CMD   = 8'h05;
   localparam logic [7:0]  REG_FLASH_STAT  = 8'h06;
   localparam logic [7:0]  REG_BOOT_INFO   = 8'h07;
   // clock control fields
   localparam int unsigned CKC_SEL_BIT     = 0;
   localparam int unsigned CKC_FIX1_BIT    = 7;   // bit fixed at one
   localparam logic [7:0]  CKC_RST         = 8'h80;
   localparam logic [7:0]  CKC_WMASK       = 8'h01;
   // boot status byte
   localparam logic [7:0]  BOOT_STAT_RST   = 8'hff;
   localparam logic [7:0]  ERASED_BYTE     = 8'hff;
   localparam logic [15:0] USER_START      = 16'h0000;
   localparam logic [15:0] LOADER_START    = 16'hfc00;
   // flash geometry
   localparam int unsigned FLASH_BYTES     = 65536;
   localparam int unsigned BLOCK_BYTES     = 4096;
   localparam int unsigned BOOT_ROM_BYTES  = 1024;
   // clock divides
   localparam logic [3:0]  DIV12_LAST      = 4'd11;
   localparam logic [3:0]  DIV6_LAST       = 4'd5;
   // flash timings
   localparam int unsigned PROG_TIME_NS    = 8000;
   localparam int unsigned BLK_ERASE_MS    = 3000;
   localparam int unsigned CHIP_ERASE_MS   = 15000;
   localparam int unsigned PROG_CYC        = PROG_TIME_NS / (1000000000 / CLK_HZ);
   localparam longint      BLK_ERASE_CYC   = longint'(BLK_ERASE_MS) * (CLK_HZ / 1000);
   localparam longint      CHIP_ERASE_CYC  = longint'(CHIP_ERASE_MS) * (CLK_HZ / 1000);
   // flash commands
   typedef enum logic [2:0] {
      BCM_CMD_NONE  = 3'd0,
      BCM_CMD_PROG  = 3'd1,
      BCM_CMD_BLKER = 3'd2,
      BCM_CMD_CHIP  = 3'd3,
      BCM_CMD_BSTAT = 3'd4,
      BCM_CMD_FUSE  = 3'd5,
      BCM_CMD_SEC   = 3'd6
   } bcm_cmd_e;
   // flash engine states, gray along idle -> work -> erase -> done
   typedef enum logic [1:0] {
      BCM_ST_IDLE  = 2'b00,
      BCM_ST_WORK  = 2'b01,
      BCM_ST_ERASE = 2'b11,
      BCM_ST_DONE  = 2'b10
   } bcm_state_e;
   // straps sampled at reset release
   typedef struct packed {
      logic prog_strobe_n;
      logic ext_access_n;
      logic addr_latch;
   } bcm_strap_s;
endpackage

//--- design/bcm_flash_mem.sv
// Purpose: byte wide user code flash array with registered read data
// Assumes: erase is done by the caller as a sequence of byte writes of ff
// Notes:   no init file; contents start unknown as a real array would
`timescale 1ns/100ps
`default_nettype none
module bcm_flash_mem #(
   parameter int unsigned AW = 16
) (
   input  wire logic          clk,   // core clock
   input  wire logic          we,    // byte write strobe
   input  wire logic [AW-1:0] waddr, // write address
   input  wire logic [7:0]    wdata, // write data
   input  wire logic [AW-1:0] raddr, // read address
   output logic      [7:0]    rdata_ff // registered read data
);
   logic [7:0] mem [0:(1<<AW)-1];

   // one byte port each way, read data registered
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_ff <= mem[raddr];
   end
endmodule
`default_nettype wire

//--- tb/bcm_strap_model.sv
// Purpose: board strap pins seen by the boot select block at reset release
// Assumes: strap_mode is held steady around reset release
// Notes:   an open address latch pin reads high through its pull-up
`timescale 1ns/100ps
`default_nettype none
module bcm_strap_model (
   input  wire logic [1:0] strap_mode,      // 0 run, 1 external code, 2 forced loader
   output logic            prog_strobe_pin, // program store strobe, low active
   output logic            ext_access_pin,  // external access, low active
   output logic            addr_latch_pin   // address latch strobe, pulled up
);
   // forced loader needs strobe low, access high, latch high or open
   always_comb begin
      prog_strobe_pin = (strap_mode != 2'h2);
      ext_access_pin  = (strap_mode != 2'h1);
      addr_latch_pin  = 1'b1;
   end
endmodule
`default_nettype wire

//--- tb/tb_boot_and_clock_mode_select.sv
// Purpose: self-checking bench for the boot and clock mode select block
// Assumes: erase lengths shortened to 10 cycles, plus the address sweep
// Notes:   nvm bits persist over srst, so each reset boots from what was stored
`timescale 1ns/100ps
`default_nettype none
module tb_boot_and_clock_mode_select
   import bcm_pkg::*;
;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [1:0]  strap_mode = 2'h0;
   logic        prog_strobe_pin, ext_access_pin, addr_latch_pin;
   logic [7:0]  reg_rdata;
   logic        core_tick, six_clk_mode, boot_valid, boot_loader, ext_code;
   logic [15:0] start_addr;
   int          mismatches = 0;
   int          compares = 0;
   logic [7:0]  d;

   // 50 ns period
   always #25 clk = ~clk;

   bcm_strap_model straps (.strap_mode(strap_mode), .prog_strobe_pin(prog_strobe_pin),
                           .ext_access_pin(ext_access_pin), .addr_latch_pin(addr_latch_pin));

   bcm_boot_clk_sel #(.BLK_ERASE_CYCLES(10), .CHIP_ERASE_CYCLES(10)) dut (
      .clk(clk), .srst(srst), .prog_strobe_pin(prog_strobe_pin), .ext_access_pin(ext_access_pin),
      .addr_latch_pin(addr_latch_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_tick(core_tick), .six_clk_mode(six_clk_mode),
      .boot_valid(boot_valid), .boot_loader(boot_loader), .start_addr(start_addr), .ext_code(ext_code));

   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one-cycle strobes; a gap cycle between requests keeps drivers simple
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // step off the edge so callers see the register the write just updated
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   // poll busy with a bound, erase sweeps are long
   task automatic wait_idle();
      logic [7:0] v;
      int n;
      n = 0;
      do begin
         rd(REG_FLASH_STAT, v);
         n++;
      end while (v[0] !== 1'b0 && n < 40000);
      check("flash idle", {15'h0, v[0]}, 16'h0);
   endtask

   task automatic do_reset(input logic [1:0] mode);
      @(posedge clk);
      strap_mode <= mode;
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic tick_period(input int exp);
      int n;
      repeat (30) begin
         @(posedge clk);
         #1;
         if (core_tick === 1'b1) break;
      end
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (core_tick !== 1'b1 && n < 30);
      check("tick period", 16'(n), 16'(exp));
   endtask

   // defaults after reset with plain straps
   task automatic t_reset_vals();
      rd(REG_BOOT_STAT, d);
      check("boot status", {8'h0, d}, {8'h0, BOOT_STAT_RST});
      rd(REG_CLK_CTRL, d);
      check("clock ctrl", {8'h0, d}, {8'h0, CKC_RST});
      check("six mode", {15'h0, six_clk_mode}, 16'h0);
      check("boot valid", {15'h0, boot_valid}, 16'h1);
      check("loader", {15'h0, boot_loader}, 16'h1);
      check("start", start_addr, LOADER_START);
      check("ext code", {15'h0, ext_code}, 16'h0);
      tick_period(12);
   endtask

   // select bit with erased fuse, fixed bit kept, unmapped index inert
   task automatic t_clk_sel();
      wr(REG_CLK_CTRL, 8'h81);
      rd(REG_CLK_CTRL, d);
      check("clock ctrl sel", {8'h0, d & 8'h81}, 16'h0081);
      check("six mode sel", {15'h0, six_clk_mode}, 16'h1);
      tick_period(6);
      wr(REG_CLK_CTRL, 8'h80);
      check("six mode clr", {15'h0, six_clk_mode}, 16'h0);
      wr(8'h20, 8'h55);
      rd(8'h20, d);
      check("unmapped", {8'h0, d}, 16'h0);
   endtask

   // status byte and strap combinations taken at reset release
   task automatic t_straps();
      wr(REG_FLASH_CMD, 8'h04);
      wait_idle();
      do_reset(2'h0);
      check("user boot", {15'h0, boot_loader}, 16'h0);
      check("user start", start_addr, USER_START);
      do_reset(2'h1);
      check("ext strap", {15'h0, ext_code}, 16'h1);
      do_reset(2'h2);
      check("forced loader", {15'h0, boot_loader}, 16'h1);
      @(posedge clk);
      strap_mode <= 2'h0;
      repeat (5) @(posedge clk);
      #1;
      check("loader held", {15'h0, boot_loader}, 16'h1);
      check("start held", start_addr, LOADER_START);
      do_reset(2'h0);
   endtask

   // status byte, fuse, erase and program through the command register
   task automatic t_flash();
      wr(REG_FLASH_CMD, 8'h04);
      wait_idle();
      rd(REG_BOOT_STAT, d);
      check("status cleared", {8'h0, d}, 16'h0);
      wr(REG_FLASH_CMD, 8'h05);
      wait_idle();
      check("fuse six", {15'h0, six_clk_mode}, 16'h1);
      tick_period(6);
      wr(REG_FLASH_ADDR_L, 8'h23);
      wr(REG_FLASH_ADDR_H, 8'h01);
      wr(REG_FLASH_CMD, 8'h02);
      wait_idle();
      rd(REG_BOOT_STAT, d);
      check("status after blk", {8'h0, d}, 16'h0);
      rd(REG_FLASH_DATA, d);
      check("blk erased", {8'h0, d}, {8'h0, ERASED_BYTE});
      wr(REG_FLASH_DATA, 8'h5a);
      wr(REG_FLASH_CMD, 8'h01);
      repeat (100) @(posedge clk);
      rd(REG_FLASH_STAT, d);
      check("prog busy", {15'h0, d[0]}, 16'h1);
      repeat (70) @(posedge clk);
      rd(REG_FLASH_STAT, d);
      check("prog done", {15'h0, d[0]}, 16'h0);
      rd(REG_FLASH_DATA, d);
      check("prog byte", {8'h0, d}, 16'h005a);
      wr(REG_FLASH_CMD, 8'h03);
      wait_idle();
      rd(REG_BOOT_STAT, d);
      check("status chip", {8'h0, d}, 16'h00ff);
      check("fuse erased", {15'h0, six_clk_mode}, 16'h0);
      rd(REG_BOOT_INFO, d);
      check("info fuse", {15'h0, d[3]}, 16'h0);
      rd(REG_FLASH_DATA, d);
      check("chip erased", {8'h0, d}, {8'h0, ERASED_BYTE});
      do_reset(2'h0);
      check("loader after erase", {15'h0, boot_loader}, 16'h1);
      // security bit one freezes the external access choice at release
      wr(REG_FLASH_DATA, 8'h00);
      wr(REG_FLASH_CMD, 8'h06);
      wait_idle();
      rd(REG_FLASH_STAT, d);
      check("sec bit one", {8'h0, d}, 16'h0002);
      do_reset(2'h1);
      @(posedge clk);
      strap_mode <= 2'h0;
      repeat (5) @(posedge clk);
      #1;
      check("ext latched", {15'h0, ext_code}, 16'h1);
   endtask

   // hang guard, above the ~71k cycles the sequence needs
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      complete_run();
   end

   initial begin
      do_reset(2'h0);
      t_reset_vals();
      t_clk_sel();
      t_straps();
      t_flash();
      complete_run();
   end
endmodule
`default_nettype wire
